/* design/sgc_pkg.sv */
`default_nettype none
package sgc_pkg;
  localparam int NUM_PORTS = 5;
  localparam int DATA_W = 8;
  localparam int AVL_ADDR_W = 8;
  localparam int VID_W = 12;
  localparam int STORM_W = 11;

  // Printed register offsets are indices; byte address is index times four
  localparam logic [AVL_ADDR_W-1:0] IDX_MIRROR_CTRL = 8'h05;
  localparam logic [AVL_ADDR_W-1:0] IDX_P5_STORM_HI = 8'h06;
  localparam logic [AVL_ADDR_W-1:0] IDX_STORM_LO = 8'h07;
  localparam logic [AVL_ADDR_W-1:0] IDX_STATS_CTRL = 8'h08;
  localparam logic [AVL_ADDR_W-1:0] ADDR_MIRROR_CTRL = 8'(IDX_MIRROR_CTRL * 4);
  localparam logic [AVL_ADDR_W-1:0] ADDR_P5_STORM_HI = 8'(IDX_P5_STORM_HI * 4);
  localparam logic [AVL_ADDR_W-1:0] ADDR_STORM_LO = 8'(IDX_STORM_LO * 4);
  localparam logic [AVL_ADDR_W-1:0] ADDR_STATS_CTRL = 8'(IDX_STATS_CTRL * 4);

  // Field positions
  localparam int MIRROR_MATCH_BIT = 0;
  localparam int P5_BACKPRESSURE_BIT = 7;
  localparam int P5_HALF_DUPLEX_BIT = 6;
  localparam int P5_FLOW_CTRL_BIT = 5;
  localparam int P5_RATE_10M_BIT = 4;
  localparam int ZERO_VID_REPLACE_BIT = 3;
  localparam int STORM_HI_MSB = 2;
  localparam int STATS_FLUSH_BIT = 7;
  localparam int STATS_FREEZE_BIT = 6;
  localparam int STATS_EN_MSB = 4;

  // Values after reset
  localparam logic [DATA_W-1:0] RST_MIRROR_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_P5_STORM_HI = 8'h00;
  localparam logic [DATA_W-1:0] RST_STORM_LO = 8'h4a;
  localparam logic [DATA_W-1:0] RST_STATS_CTRL = 8'h00;

  // Storm measurement periods
  localparam int CLK_MHZ = 250;
  localparam int PERIOD_100M_MS = 50;
  localparam int PERIOD_10M_MS = 500;
  localparam int unsigned PERIOD_100M_CYC = PERIOD_100M_MS * 1000 * CLK_MHZ;
  localparam int unsigned PERIOD_10M_CYC = PERIOD_10M_MS * 1000 * CLK_MHZ;
endpackage : sgc_pkg
`default_nettype wire

/* design/sgc_storm_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sgc_storm_if;
  logic [sgc_pkg::STORM_W-1:0] threshold;
  logic period_tick;
  logic block_pulse;
  logic drop;

  modport limiter (input threshold, input period_tick, input block_pulse, output drop);
  modport ctrl (output threshold, output period_tick, output block_pulse, input drop);
endinterface : sgc_storm_if
`default_nettype wire

/* design/sgc_storm_limiter.sv */
`timescale 1ns/10ps
`default_nettype none
module sgc_storm_limiter (
  input wire logic core_clk_i,
  input wire logic reset_i,
  sgc_storm_if.limiter sif
);
  import sgc_pkg::*;

  logic [STORM_W-1:0] count_reg;
  logic [STORM_W-1:0] count_next;
  logic drop_reg;
  logic drop_next;
  wire logic below_limit;

  assign below_limit = count_reg < sif.threshold;

  // New period restarts the count; a block in the tick cycle opens it
  always_comb begin
    count_next = count_reg;
    if (sif.period_tick) begin
      count_next = sif.block_pulse ? STORM_W'(1) : '0;
    end else if (sif.block_pulse && below_limit) begin
      count_next = count_reg + STORM_W'(1);
    end
    drop_next = count_next >= sif.threshold;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= '0;
      drop_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      drop_reg <= drop_next;
    end
  end

  assign sif.drop = drop_reg;
endmodule : sgc_storm_limiter
`default_nettype wire

/* design/sgc_global_ctrl.sv */
// Summary of operation
// - Match mode 1: mirror when source and destination selected
// - Match mode 0: mirror when either port selected
// - Port 5 back pressure enable bit
// - Port 5 duplex select, 1 half
// - Port 5 full-duplex pause flow control enable
// - Port 5 rate select, 1 is 10M
// - Replace zero VLAN ID with port default
// - Eleven-bit storm threshold in 64-byte blocks
// - Storm period 50 ms fast, 500 ms slow
// - Flush clears counters of enabled ports
// - Flush bit self-clears when flush completes
// - Freeze holds counters of enabled ports
// - Five per-port enables for flush and freeze
`timescale 1ns/10ps
`default_nettype none
module sgc_global_ctrl #(
  parameter int unsigned PERIOD_100M_CYC = sgc_pkg::PERIOD_100M_CYC,
  parameter int unsigned PERIOD_10M_CYC = sgc_pkg::PERIOD_10M_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [sgc_pkg::AVL_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic frame_valid_i,
  input wire logic src_mirror_i,
  input wire logic dst_mirror_i,
  output logic mirror_copy_o,
  output logic p5_backpressure_o,
  output logic p5_half_duplex_o,
  output logic p5_flow_ctrl_o,
  output logic p5_rate_10m_o,
  input wire logic tag_valid_i,
  input wire logic [sgc_pkg::VID_W-1:0] tag_vid_i,
  input wire logic [sgc_pkg::VID_W-1:0] port_default_vlan_id_i,
  output logic tag_valid_o,
  output logic [sgc_pkg::VID_W-1:0] tag_vid_o,
  input wire logic [sgc_pkg::NUM_PORTS-2:0] port_rate_10m_i,
  input wire logic [sgc_pkg::NUM_PORTS-1:0] bcast_block_i,
  output logic [sgc_pkg::NUM_PORTS-1:0] storm_drop_o,
  output logic [sgc_pkg::NUM_PORTS-1:0] stats_flush_o,
  output logic [sgc_pkg::NUM_PORTS-1:0] stats_freeze_o,
  input wire logic stats_flush_done_i
);
  import sgc_pkg::*;

  localparam int TMR_W = $clog2(PERIOD_10M_CYC + 1);
  localparam logic [TMR_W-1:0] LAST_100M = TMR_W'(PERIOD_100M_CYC - 1);
  localparam logic [TMR_W-1:0] LAST_10M = TMR_W'(PERIOD_10M_CYC - 1);

  // Registers
  logic [DATA_W-1:0] mirror_ctrl_reg;
  logic [DATA_W-1:0] mirror_ctrl_next;
  logic [DATA_W-1:0] p5_storm_hi_reg;
  logic [DATA_W-1:0] p5_storm_hi_next;
  logic [DATA_W-1:0] storm_lo_reg;
  logic [DATA_W-1:0] storm_lo_next;
  logic [DATA_W-1:0] stats_ctrl_reg;
  logic [DATA_W-1:0] stats_ctrl_next;

  // Bus handshake
  logic wait_reg;
  logic [31:0] rdata_reg;

  wire logic req_pending;
  wire logic accept;
  wire logic wr_en;
  wire logic hit_mirror;
  wire logic hit_p5;
  wire logic hit_lo;
  wire logic hit_stats;
  wire logic [DATA_W-1:0] wbyte;
  wire logic [DATA_W-1:0] rd_byte;

  assign req_pending = avs_read_i | avs_write_i;
  // One wait cycle per access; read data lands on the edge wait falls, write on the edge wait is low
  assign accept = req_pending & ~wait_reg;
  assign wr_en = avs_write_i & accept & avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[DATA_W-1:0];
  assign hit_mirror = avs_address_i == ADDR_MIRROR_CTRL;
  assign hit_p5 = avs_address_i == ADDR_P5_STORM_HI;
  assign hit_lo = avs_address_i == ADDR_STORM_LO;
  assign hit_stats = avs_address_i == ADDR_STATS_CTRL;

  // Unmapped addresses read zero and swallow writes
  assign rd_byte = hit_mirror ? mirror_ctrl_reg :
                   hit_p5 ? p5_storm_hi_reg :
                   hit_lo ? storm_lo_reg :
                   hit_stats ? stats_ctrl_reg : '0;

  // Only the match-mode bit lives in the mirror register here
  assign mirror_ctrl_next = (wr_en && hit_mirror) ?
                            {{(DATA_W-1){1'b0}}, wbyte[MIRROR_MATCH_BIT]} : mirror_ctrl_reg;
  assign p5_storm_hi_next = (wr_en && hit_p5) ? wbyte : p5_storm_hi_reg;
  assign storm_lo_next = (wr_en && hit_lo) ? wbyte : storm_lo_reg;

  // Flush: a fresh write of one beats the completion strobe
  wire logic flush_set;
  wire logic flush_keep;
  wire logic flush_bit_next;
  assign flush_set = wr_en && hit_stats && wbyte[STATS_FLUSH_BIT];
  assign flush_keep = (wr_en && hit_stats) ? 1'b0 : stats_ctrl_reg[STATS_FLUSH_BIT] & ~stats_flush_done_i;
  assign flush_bit_next = flush_set | flush_keep;
  assign stats_ctrl_next[STATS_FLUSH_BIT] = flush_bit_next;
  assign stats_ctrl_next[STATS_FREEZE_BIT] = (wr_en && hit_stats) ? wbyte[STATS_FREEZE_BIT] :
                                             stats_ctrl_reg[STATS_FREEZE_BIT];
  assign stats_ctrl_next[5] = 1'b0;
  assign stats_ctrl_next[STATS_EN_MSB:0] = (wr_en && hit_stats) ? wbyte[STATS_EN_MSB:0] :
                                           stats_ctrl_reg[STATS_EN_MSB:0];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mirror_ctrl_reg <= RST_MIRROR_CTRL;
      p5_storm_hi_reg <= RST_P5_STORM_HI;
      storm_lo_reg <= RST_STORM_LO;
      stats_ctrl_reg <= RST_STATS_CTRL;
    end else begin
      mirror_ctrl_reg <= mirror_ctrl_next;
      p5_storm_hi_reg <= p5_storm_hi_next;
      storm_lo_reg <= storm_lo_next;
      stats_ctrl_reg <= stats_ctrl_next;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg <= ~(req_pending & wait_reg);
      if (req_pending && wait_reg) begin
        rdata_reg <= {{(32-DATA_W){1'b0}}, rd_byte};
      end
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

  // Port 5 link settings come straight from register bits
  assign p5_backpressure_o = p5_storm_hi_reg[P5_BACKPRESSURE_BIT];
  assign p5_half_duplex_o = p5_storm_hi_reg[P5_HALF_DUPLEX_BIT];
  assign p5_flow_ctrl_o = p5_storm_hi_reg[P5_FLOW_CTRL_BIT];
  assign p5_rate_10m_o = p5_storm_hi_reg[P5_RATE_10M_BIT];

  // Mirroring decision, one cycle behind the frame strobe
  logic mirror_copy_reg;
  wire logic match_both;
  wire logic match_either;
  wire logic mirror_copy_next;
  assign match_both = src_mirror_i & dst_mirror_i;
  assign match_either = src_mirror_i | dst_mirror_i;
  assign mirror_copy_next = frame_valid_i &
                            (mirror_ctrl_reg[MIRROR_MATCH_BIT] ? match_both : match_either);

  // Zero VLAN ID substitution, also one cycle of latency
  logic tag_valid_reg;
  logic [VID_W-1:0] tag_vid_reg;
  wire logic vid_is_zero;
  wire logic [VID_W-1:0] tag_vid_next;
  assign vid_is_zero = tag_vid_i == '0;
  assign tag_vid_next = (p5_storm_hi_reg[ZERO_VID_REPLACE_BIT] && vid_is_zero) ?
                        port_default_vlan_id_i : tag_vid_i;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mirror_copy_reg <= 1'b0;
      tag_valid_reg <= 1'b0;
      tag_vid_reg <= '0;
    end else begin
      mirror_copy_reg <= mirror_copy_next;
      tag_valid_reg <= tag_valid_i;
      tag_vid_reg <= tag_vid_next;
    end
  end

  assign mirror_copy_o = mirror_copy_reg;
  assign tag_valid_o = tag_valid_reg;
  assign tag_vid_o = tag_vid_reg;

  // Statistics control; an empty mask leaves every port untouched
  logic [NUM_PORTS-1:0] flush_out_reg;
  logic [NUM_PORTS-1:0] freeze_out_reg;
  wire logic [NUM_PORTS-1:0] port_mask;
  assign port_mask = stats_ctrl_reg[STATS_EN_MSB:0];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flush_out_reg <= '0;
      freeze_out_reg <= '0;
    end else begin
      flush_out_reg <= stats_ctrl_reg[STATS_FLUSH_BIT] ? port_mask : '0;
      freeze_out_reg <= stats_ctrl_reg[STATS_FREEZE_BIT] ? port_mask : '0;
    end
  end

  assign stats_flush_o = flush_out_reg;
  assign stats_freeze_o = freeze_out_reg;

  // Two free-running period timers shared by all ports
  logic [TMR_W-1:0] tmr_100m_reg;
  logic [TMR_W-1:0] tmr_10m_reg;
  logic tick_100m_reg;
  logic tick_10m_reg;
  wire logic end_100m;
  wire logic end_10m;
  assign end_100m = tmr_100m_reg == LAST_100M;
  assign end_10m = tmr_10m_reg == LAST_10M;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tmr_100m_reg <= '0;
      tmr_10m_reg <= '0;
      tick_100m_reg <= 1'b0;
      tick_10m_reg <= 1'b0;
    end else begin
      tmr_100m_reg <= end_100m ? '0 : tmr_100m_reg + TMR_W'(1);
      tmr_10m_reg <= end_10m ? '0 : tmr_10m_reg + TMR_W'(1);
      tick_100m_reg <= end_100m;
      tick_10m_reg <= end_10m;
    end
  end

  wire logic [STORM_W-1:0] storm_threshold;
  wire logic [NUM_PORTS-1:0] port_is_10m;
  assign storm_threshold = {p5_storm_hi_reg[STORM_HI_MSB:0], storm_lo_reg};
  // Port 5 rate is owned by its own register bit
  assign port_is_10m = {p5_storm_hi_reg[P5_RATE_10M_BIT], port_rate_10m_i};

  sgc_storm_if storm_bus[NUM_PORTS] ();

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_storm
    assign storm_bus[p].threshold = storm_threshold;
    assign storm_bus[p].period_tick = port_is_10m[p] ? tick_10m_reg : tick_100m_reg;
    assign storm_bus[p].block_pulse = bcast_block_i[p];
    assign storm_drop_o[p] = storm_bus[p].drop;

    sgc_storm_limiter u_limiter (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .sif(storm_bus[p])
    );
  end
endmodule : sgc_global_ctrl
`default_nettype wire

/* dv/sgc_global_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module sgc_global_ctrl_chk (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic frame_valid_i,
  input wire logic src_mirror_i,
  input wire logic dst_mirror_i,
  input wire logic mirror_copy_o,
  input wire logic [11:0] tag_vid_i,
  input wire logic [11:0] port_default_vlan_id_i,
  input wire logic [11:0] tag_vid_o,
  input wire logic stats_flush_done_i,
  input wire logic [4:0] stats_flush_o,
  input wire logic [4:0] stats_freeze_o,
  input wire logic p5_rate_10m_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one cycle");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_mirror_both: assert property (frame_valid_i && src_mirror_i && dst_mirror_i |=> mirror_copy_o)
    else $error("frame with both ports selected not mirrored");
  a_mirror_none: assert property (!(frame_valid_i && (src_mirror_i || dst_mirror_i)) |=> !mirror_copy_o)
    else $error("frame mirrored with no port selected");
  a_vid_keep: assert property (tag_vid_i != 12'h000 |=> tag_vid_o == $past(tag_vid_i))
    else $error("nonzero vlan id altered");
  a_vid_zero: assert property (tag_vid_i == 12'h000 |=>
    tag_vid_o == 12'h000 || tag_vid_o == $past(port_default_vlan_id_i)) else $error("zero vlan id wrong");
  a_flush_clear: assert property (stats_flush_done_i && !avs_write_i |=> ##1 stats_flush_o == 5'h00)
    else $error("flush still active after done");
  a_link_hold: assert property (!$past(avs_write_i) |-> $stable(p5_rate_10m_o))
    else $error("port 5 rate changed without a write");
  a_freeze_hold: assert property (!$past(avs_write_i, 2) |-> $stable(stats_freeze_o))
    else $error("freeze mask changed without a write");
  cover property (avs_write_i && !avs_waitrequest_o);
  cover property (stats_flush_done_i && stats_flush_o != 5'h00);
  cover property ($rose(mirror_copy_o));
endmodule : sgc_global_ctrl_chk

bind sgc_global_ctrl sgc_global_ctrl_chk u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .frame_valid_i(frame_valid_i), .src_mirror_i(src_mirror_i), .dst_mirror_i(dst_mirror_i),
  .mirror_copy_o(mirror_copy_o), .tag_vid_i(tag_vid_i), .port_default_vlan_id_i(port_default_vlan_id_i),
  .tag_vid_o(tag_vid_o), .stats_flush_done_i(stats_flush_done_i), .stats_flush_o(stats_flush_o),
  .stats_freeze_o(stats_freeze_o), .p5_rate_10m_o(p5_rate_10m_o));
`default_nettype wire

/* dv/sgc_global_ctrl_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sgc_global_ctrl_tb_top;
  import sgc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h1;
  logic fv = 1'b0, sm = 1'b0, dm = 1'b0, tv = 1'b0, dn = 1'b0;
  logic [11:0] vid = 12'h000;
  logic [4:0] bb = 5'h00;
  logic [31:0] rdat, q;
  logic [11:0] vo;
  logic [4:0] sd, fo, fz;
  logic [3:0] p5;
  logic wt, mc, tvo;
  int bad_count = 0;
  int tests_run = 0;
  int i, m, c;
  always #2 clk = ~clk;

  sgc_global_ctrl #(.PERIOD_100M_CYC(20), .PERIOD_10M_CYC(200)) dut (.core_clk_i(clk), .reset_i(rst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .frame_valid_i(fv), .src_mirror_i(sm),
    .dst_mirror_i(dm), .mirror_copy_o(mc), .p5_backpressure_o(p5[3]), .p5_half_duplex_o(p5[2]),
    .p5_flow_ctrl_o(p5[1]), .p5_rate_10m_o(p5[0]), .tag_valid_i(tv), .tag_vid_i(vid),
    .port_default_vlan_id_i(12'h5a5), .tag_valid_o(tvo), .tag_vid_o(vo), .port_rate_10m_i(4'h4),
    .bcast_block_i(bb), .storm_drop_o(sd), .stats_flush_o(fo), .stats_freeze_o(fz), .stats_flush_done_i(dn));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  // Request held until waitrequest is sampled low, then released
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (wt === 1'b0) break;
    end
    if (k == 20) begin
      chk("waitrequest", 32'h0, {31'h0, wt});
      conclude();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("readdata", {24'h0, e}, q);
  endtask : rchk
  // One block pulse, then a quiet cycle so the strobe is never set twice in one step
  task automatic bp(input logic [4:0] p);
    bb <= p;
    tk(1);
    bb <= 5'h00;
    tk(1);
  endtask : bp

  initial begin
    tk(2);
    rst <= 1'b0;
    tk(1);
    rchk(8'h14, 8'h00);
    rchk(8'h18, 8'h00);
    rchk(8'h1c, 8'h4a);
    rchk(8'h20, 8'h00);
    for (i = 4; i < 8; i++) begin
      acc(1'b1, 8'h18, 8'h01 << i);
      tk(1);
      chk("p5_link", 32'h1 << (i - 4), {28'h0, p5});
    end
    be <= 4'h0;
    acc(1'b1, 8'h1c, 8'h55);
    be <= 4'h1;
    rchk(8'h1c, 8'h4a);
    acc(1'b1, 8'h24, 8'hff);
    rchk(8'h24, 8'h00);
    acc(1'b1, 8'h20, 8'h3f);
    rchk(8'h20, 8'h1f);
    acc(1'b1, 8'h18, 8'h07);
    rchk(8'h18, 8'h07);
    for (m = 0; m < 2; m++) begin
      acc(1'b1, 8'h14, m[7:0]);
      for (c = 0; c < 4; c++) begin
        {sm, dm} <= c[1:0];
        fv <= 1'b1;
        tk(2);
        chk("mirror", (m == 1) ? (c == 3) : (c != 0), {31'h0, mc});
      end
      fv <= 1'b0;
      tk(2);
      chk("mirror_idle", 32'h0, {31'h0, mc});
    end
    tv <= 1'b1;
    for (m = 0; m < 2; m++) begin
      acc(1'b1, 8'h18, 8'(m << 3));
      vid <= 12'h000;
      tk(2);
      chk("vid_zero", (m == 1) ? 32'h5a5 : 32'h0, {20'h0, vo});
      vid <= 12'h123;
      tk(2);
      chk("vid_keep", 32'h123, {20'h0, vo});
      chk("tag_valid", 32'h1, {31'h0, tvo});
    end
    acc(1'b1, 8'h20, 8'h95);
    tk(1);
    chk("flush_mask", 32'h15, {27'h0, fo});
    rchk(8'h20, 8'h95);
    dn <= 1'b1;
    tk(1);
    dn <= 1'b0;
    tk(2);
    chk("flush_end", 32'h0, {27'h0, fo});
    rchk(8'h20, 8'h15);
    acc(1'b1, 8'h20, 8'h4a);
    tk(1);
    chk("freeze_mask", 32'h0a, {27'h0, fz});
    acc(1'b1, 8'h18, 8'h00);
    acc(1'b1, 8'h1c, 8'h03);
    // Align to a period boundary through port 2 before counting on port 1
    for (i = 0; i < 8 && sd[1] !== 1'b1; i++) bp(5'h02);
    for (i = 0; i < 30 && sd[1] !== 1'b0; i++) tk(1);
    chk("storm_sync", 32'h0, {31'h0, sd[1]});
    bp(5'h01);
    bp(5'h01);
    chk("storm_below", 32'h0, {27'h0, sd});
    bp(5'h01);
    tk(1);
    chk("storm_drop", 32'h01, {27'h0, sd});
    for (i = 0; i < 30 && sd[0] !== 1'b0; i++) tk(1);
    chk("storm_period", 32'h1, {31'h0, i > 3 && i < 20});
    // Port 3 is tied to the slow rate, so its drop must last the long period
    for (i = 0; i < 8 && sd[2] !== 1'b1; i++) bp(5'h04);
    for (i = 0; i < 230 && sd[2] !== 1'b0; i++) tk(1);
    chk("storm_sync_10m", 32'h0, {31'h0, sd[2]});
    bp(5'h04);
    bp(5'h04);
    bp(5'h04);
    tk(1);
    chk("storm_drop_10m", 32'h04, {27'h0, sd});
    for (i = 0; i < 230 && sd[2] !== 1'b0; i++) tk(1);
    chk("storm_period_10m", 32'h1, {31'h0, i > 150 && i < 210});
    conclude();
  end
endmodule : sgc_global_ctrl_tb_top
`default_nettype wire
